// >>> design/mrs_pkg.sv
// constants, carrier types and shared functions of the rtu slave framer
// Operation
// - eight-bit character spans eleven bit times
// - seven or eight data bits, lsb first
// - optional odd or even parity bit
// - one stop with parity, two without
// - transmit only after 3.5 character idle
// - address, function, data, then check field
// - 3.5 character idle ends received frame
// - transmitted bytes follow back to back
// - gap over 1.5 characters drops partial frame
// - short inter-frame gap appends, check fails
// - address byte 0 to 247, 0 broadcast
// - answer individual frames, never broadcasts
// - address byte decides whether frame targets us
// - function codes 03h read, 06h write
// - data field holds an even byte count
// - check value sent low byte first
// - never drive transmitter while receiving
// - all nodes share identical line settings
// - binary rtu mode only, no ascii
// - bit rate chosen from listed bps values
// - crc from ffff, poly a001, right shift
// - recomputed check mismatch means error
// - even parity one on odd count of ones
package mrs_pkg;

  // bit rates in bits per second
  localparam int RATE_2400 = 2400;
  localparam int RATE_4800 = 4800;
  localparam int RATE_9600 = 9600;
  localparam int RATE_19200 = 19200;

  // codes of the baud rate setting
  localparam logic [1:0] BAUD_2400 = 2'h0;
  localparam logic [1:0] BAUD_4800 = 2'h1;
  localparam logic [1:0] BAUD_9600 = 2'h2;
  localparam logic [1:0] BAUD_19200 = 2'h3;

  // character lengths in bit times, start and stop included
  localparam logic [3:0] CHAR_BITS_8 = 4'hB;
  localparam logic [3:0] CHAR_BITS_7 = 4'hA;

  // gaps in tenths of a character time
  localparam int GAP_INTRA_TENTHS = 15;
  localparam int GAP_FRAME_TENTHS = 35;
  localparam int TENTHS = 10;

  // frame layout and check value
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] FUNC_WRITE = 8'h06;
  localparam logic [8:0] FRAME_MIN_LEN = 9'h004;
  localparam int FRAME_LEN_W = 9;
  localparam int TIMER_W = 22;

  // transmit phases: user bytes, check low, check high, finished
  localparam logic [1:0] PH_USER = 2'h0;
  localparam logic [1:0] PH_CRC_LO = 2'h1;
  localparam logic [1:0] PH_CRC_HI = 2'h2;
  localparam logic [1:0] PH_DONE = 2'h3;

  // line settings shared by every node
  typedef struct packed {
    logic [1:0] baud;     // baud rate setting code
    logic data8;          // 1: eight data bits, 0: seven
    logic par_en;         // parity bit present
    logic par_odd;        // 1: odd parity, 0: even
    logic [7:0] addr;     // own slave address
  } mrs_cfg_s;

  // description of an accepted frame
  typedef struct packed {
    logic [FRAME_LEN_W-1:0] len;  // bytes incl. address and check
    logic [7:0] func;             // function code byte
    logic bcast;                  // frame was a broadcast
  } mrs_frame_s;

  // clock cycles per bit for a rate code
  function automatic int bit_div(input int clk_hz, input logic [1:0] code);
    int r;
    case (code)
      BAUD_2400: r = clk_hz / RATE_2400;
      BAUD_4800: r = clk_hz / RATE_4800;
      BAUD_9600: r = clk_hz / RATE_9600;
      default: r = clk_hz / RATE_19200;
    endcase
    return r;
  endfunction

  // gap length in clocks; least times round up, longest round down
  function automatic int gap_clk(input int div, input int bits,
                                 input int tenths, input logic up);
    int p;
    p = div * bits * tenths;
    return up ? (p + TENTHS - 1) / TENTHS : p / TENTHS;
  endfunction

  // one byte through the check value register, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      if (c[0])
        c = (c >> 1) ^ CRC_POLY;
      else
        c = c >> 1;
    end
    return c;
  endfunction

  // parity bit over the used data bits
  function automatic logic par_bit(input logic [7:0] d, input logic d8,
                                   input logic odd);
    logic [7:0] m;
    m = d8 ? d : {1'b0, d[6:0]};
    return (^m) ^ odd;
  endfunction

endpackage

// >>> design/mrs_frame_ram.sv
// receive frame buffer: one write port, registered read port
module mrs_frame_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_in,               // system clock
  input wire logic ce_in,                // clock enable
  input wire logic wr_en_in,             // write strobe
  input wire logic [AW-1:0] wr_addr_in,  // write address
  input wire logic [WIDTH-1:0] wr_data_in,  // write data
  input wire logic [AW-1:0] rd_addr_in,  // read address
  output logic [WIDTH-1:0] rd_data_out   // registered read data
);

  // storage array
  logic [WIDTH-1:0] mem [DEPTH];

  // write port and registered read port
  always_ff @(posedge clk_in)
  begin
    if (ce_in)
    begin
      if (wr_en_in)
        mem[wr_addr_in] <= wr_data_in;
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule

// >>> design/mrs_framer.sv
// rtu slave link layer: character timing, frame delimiting and check
module mrs_framer #(
  parameter int CLK_HZ = 20_000_000,  // system clock rate
  parameter int DEPTH = 256,          // receive buffer bytes
  parameter int AW = 8                // receive buffer address width
) (
  input wire logic clk_in,                 // system clock at CLK_HZ
  input wire logic rst_in,                 // synchronous reset, high
  input wire logic ce_in,                  // clock enable, freezes all
  input wire logic rx_in,                  // line receive pin
  output logic tx_out,                     // line transmit data
  output logic tx_oe_n_out,                // driver enable, low drives
  input wire mrs_pkg::mrs_cfg_s cfg_in,    // line settings
  output logic frame_ok_out,               // accepted frame pulse
  output mrs_pkg::mrs_frame_s frame_out,   // accepted frame info
  input wire logic [AW-1:0] rd_addr_in,    // buffer read address
  output logic [7:0] rd_data_out,          // buffer read data
  output logic err_flag_out,               // sticky error flag
  input wire logic err_clr_in,             // clears the error flag
  output logic resp_pend_out,              // response owed to master
  input wire logic tx_valid_in,            // response byte valid
  input wire logic [7:0] tx_data_in,       // response byte
  input wire logic tx_last_in,             // last response byte
  output logic tx_ready_out                // response byte taken
);

  // configuration the logic cannot serve is refused
  if (DEPTH < 8 || DEPTH > 256 || (1 << AW) < DEPTH)
  begin : g_bad_depth
    $error("buffer depth or address width not supported");
  end
  if (mrs_pkg::gap_clk(CLK_HZ / mrs_pkg::RATE_2400, 11,
      mrs_pkg::GAP_FRAME_TENTHS, 1'b1) >= (1 << mrs_pkg::TIMER_W))
  begin : g_bad_clock
    $error("clock too fast for gap timer width");
  end

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP}
    mrs_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND} mrs_tx_e;
  localparam int TW = mrs_pkg::TIMER_W;

  // derived bit and gap timing
  logic [TW-1:0] div;          // clocks per bit
  logic [TW-1:0] half;         // clocks per half bit
  logic [TW-1:0] t15;          // longest intra-frame gap
  logic [TW-1:0] t35;          // least inter-frame gap
  logic [3:0] nbits;           // bit times per character
  logic [3:0] nsample;         // data plus parity bits to sample

  // receive path
  logic rx_meta;               // first synchroniser stage
  logic rx_sync;               // second synchroniser stage
  logic rx_prev;               // previous synchronised level
  mrs_rx_e rx_state;           // character receive state
  logic [TW-1:0] rx_cnt;       // bit timer
  logic [3:0] rx_idx;          // sampled bit index
  logic [9:0] rx_sh;           // sampled data and parity bits
  logic rx_stb;                // character complete pulse
  logic [7:0] rx_byte;         // completed character data
  logic rx_err;                // parity or framing error on it
  logic [7:0] rx_data;         // data bits of sampled character
  logic rx_par;                // parity bit of sampled character

  // frame tracking
  logic [TW-1:0] idle_cnt;     // clocks of idle line
  logic in_frame;              // frame being collected
  logic [mrs_pkg::FRAME_LEN_W-1:0] frm_len;  // bytes so far
  logic [15:0] frm_crc;        // running check value
  logic frm_bad;               // error seen in this frame
  logic [7:0] frm_addr;        // address byte
  logic [7:0] frm_func;        // function code byte
  logic wr_en;                 // buffer write strobe
  logic [AW-1:0] wr_addr;      // buffer write address
  logic [7:0] wr_data;         // buffer write data
  logic new_frame;             // this byte opens a frame
  logic frm_end;               // frame end moment
  logic frm_good;              // frame passes every check
  logic frm_ours;              // address targets this node

  // transmit path
  mrs_tx_e tx_state;           // transmit state
  logic [1:0] tx_phase;        // which byte source is next
  logic [TW-1:0] tx_cnt;       // bit timer
  logic [3:0] tx_left;         // bits left in character
  logic [10:0] tx_sh;          // character bits, lsb first
  logic [15:0] tx_crc;         // running check value
  logic tx_start;              // start of a response
  logic tx_go;                 // byte taken in fetch

  // character frame: start, data, parity, ones for stop bits
  function automatic logic [10:0] build_char(input logic [7:0] d,
                                             input mrs_pkg::mrs_cfg_s c);
    logic [10:0] f;
    f = '1;
    f[0] = 1'b0;
    if (c.data8)
    begin
      f[8:1] = d;
      if (c.par_en)
        f[9] = mrs_pkg::par_bit(d, 1'b1, c.par_odd);
    end
    else
    begin
      f[7:1] = d[6:0];
      if (c.par_en)
        f[8] = mrs_pkg::par_bit(d, 1'b0, c.par_odd);
    end
    return f;
  endfunction

  // timing from the rate setting and character length
  always_comb
  begin
    div = TW'(mrs_pkg::bit_div(CLK_HZ, cfg_in.baud));
    half = div >> 1;
    // parity and second stop trade places, length is fixed
    nbits = cfg_in.data8 ? mrs_pkg::CHAR_BITS_8
                         : mrs_pkg::CHAR_BITS_7;
    nsample = (cfg_in.data8 ? 4'h8 : 4'h7) + {3'h0, cfg_in.par_en};
    t15 = TW'(mrs_pkg::gap_clk(int'(div), int'(nbits),
              mrs_pkg::GAP_INTRA_TENTHS, 1'b0));
    t35 = TW'(mrs_pkg::gap_clk(int'(div), int'(nbits),
              mrs_pkg::GAP_FRAME_TENTHS, 1'b1));
  end

  // two-stage synchroniser on the line pin
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else if (ce_in)
    begin
      rx_meta <= rx_in;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // sampled character fields
  always_comb
  begin
    rx_data = cfg_in.data8 ? rx_sh[7:0] : {1'b0, rx_sh[6:0]};
    rx_par = cfg_in.data8 ? rx_sh[8] : rx_sh[7];
  end

  // character receiver, blanked while this node transmits
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_sh <= '0;
      rx_stb <= 1'b0;
      rx_byte <= '0;
      rx_err <= 1'b0;
    end
    else if (ce_in)
    begin
      rx_stb <= 1'b0;
      case (rx_state)
        RX_IDLE:
        begin
          // falling edge starts a character
          if (tx_oe_n_out && rx_prev && !rx_sync)
          begin
            rx_state <= RX_START;
            rx_cnt <= '0;
          end
        end
        RX_START:
        begin
          // confirm start bit at its centre
          if (rx_cnt >= half - 1'b1)
          begin
            rx_cnt <= '0;
            rx_idx <= '0;
            rx_state <= rx_sync ? RX_IDLE : RX_BITS;
          end
          else
            rx_cnt <= rx_cnt + 1'b1;
        end
        RX_BITS:
        begin
          // one full bit later is the next centre, lsb arrives first
          if (rx_cnt >= div - 1'b1)
          begin
            rx_cnt <= '0;
            rx_sh[rx_idx] <= rx_sync;
            rx_idx <= rx_idx + 1'b1;
            if (rx_idx == nsample - 1'b1)
              rx_state <= RX_STOP;
          end
          else
            rx_cnt <= rx_cnt + 1'b1;
        end
        RX_STOP:
        begin
          // first stop bit checked; a second one reads as idle line
          if (rx_cnt >= div - 1'b1)
          begin
            rx_cnt <= '0;
            rx_state <= RX_IDLE;
            rx_stb <= 1'b1;
            rx_byte <= rx_data;
            rx_err <= !rx_sync || (cfg_in.par_en &&
              rx_par != mrs_pkg::par_bit(rx_data, cfg_in.data8,
                                         cfg_in.par_odd));
          end
          else
            rx_cnt <= rx_cnt + 1'b1;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // idle line timer; held over a character, cleared by its strobe
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      idle_cnt <= '0;
    else if (ce_in)
    begin
      if (!tx_oe_n_out || rx_stb)
        idle_cnt <= '0;
      else if (rx_state == RX_IDLE && rx_sync && idle_cnt != '1)
        idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // frame boundaries and checks on the collected frame
  always_comb
  begin
    // byte after an over-long gap becomes a new address byte
    new_frame = !in_frame || idle_cnt > t15;
    frm_end = in_frame && idle_cnt == t35 && rx_state == RX_IDLE
              && !rx_stb;
    // running check over the check bytes too leaves zero when intact
    frm_good = !frm_bad && frm_crc == 16'h0000
               && frm_len >= mrs_pkg::FRAME_MIN_LEN
               && !frm_len[0]
               && frm_addr <= mrs_pkg::ADDR_MAX;
    frm_ours = frm_addr == cfg_in.addr
               || frm_addr == mrs_pkg::ADDR_BCAST;
  end

  // frame collector: bytes into buffer, running check value
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      in_frame <= 1'b0;
      frm_len <= '0;
      frm_crc <= mrs_pkg::CRC_INIT;
      frm_bad <= 1'b0;
      frm_addr <= '0;
      frm_func <= '0;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end
    else if (ce_in)
    begin
      wr_en <= 1'b0;
      if (rx_stb)
      begin
        // binary bytes stored as received, first byte is the address
        wr_en <= 1'b1;
        wr_data <= rx_byte;
        if (new_frame)
        begin
          in_frame <= 1'b1;
          frm_len <= 9'h001;
          frm_crc <= mrs_pkg::crc_byte(mrs_pkg::CRC_INIT,
                                       rx_byte);
          frm_bad <= rx_err;
          frm_addr <= rx_byte;
          wr_addr <= '0;
        end
        else
        begin
          // bytes inside the short gap extend the frame
          frm_len <= frm_len + 1'b1;
          frm_crc <= mrs_pkg::crc_byte(frm_crc, rx_byte);
          frm_bad <= frm_bad || rx_err
                     || frm_len >= DEPTH[mrs_pkg::FRAME_LEN_W-1:0];
          wr_addr <= frm_len[AW-1:0];
          if (frm_len == 9'h001)
            frm_func <= rx_byte;
        end
      end
      else if (frm_end)
        in_frame <= 1'b0;
    end
  end

  // frame verdict, response duty and error flag
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      frame_ok_out <= 1'b0;
      frame_out <= '0;
      resp_pend_out <= 1'b0;
      err_flag_out <= 1'b0;
    end
    else if (ce_in)
    begin
      frame_ok_out <= frm_end && frm_good && frm_ours;
      if (frm_end && frm_good && frm_ours)
      begin
        frame_out.len <= frm_len;
        frame_out.func <= frm_func;
        frame_out.bcast <= frm_addr == mrs_pkg::ADDR_BCAST;
      end
      // only individually addressed frames owe an answer
      if (frm_end && frm_good && frm_addr == cfg_in.addr
          && frm_addr != mrs_pkg::ADDR_BCAST)
        resp_pend_out <= 1'b1;
      else if (rx_stb && new_frame)
        resp_pend_out <= 1'b0;
      else if (tx_state == TX_SEND && tx_phase == mrs_pkg::PH_DONE)
        resp_pend_out <= 1'b0;
      // setting beats clearing in the same cycle
      if ((frm_end && !frm_good) || (rx_stb && in_frame && new_frame))
        err_flag_out <= 1'b1;
      else if (err_clr_in)
        err_flag_out <= 1'b0;
    end
  end

  // response may start only on a quiet line after the full gap
  always_comb
  begin
    tx_start = tx_state == TX_IDLE && resp_pend_out && tx_valid_in
               && !in_frame && rx_state == RX_IDLE && rx_sync
               && idle_cnt >= t35;
    tx_go = tx_state == TX_FETCH
            && (tx_phase != mrs_pkg::PH_USER || (tx_valid_in && tx_ready_out));
  end

  // transmitter: user bytes, then check low and high bytes
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_state <= TX_IDLE;
      tx_phase <= mrs_pkg::PH_USER;
      tx_cnt <= '0;
      tx_left <= '0;
      tx_sh <= '1;
      tx_crc <= mrs_pkg::CRC_INIT;
      tx_out <= 1'b1;
      tx_oe_n_out <= 1'b1;
      tx_ready_out <= 1'b0;
    end
    else if (ce_in)
    begin
      case (tx_state)
        TX_IDLE:
        begin
          tx_out <= 1'b1;
          if (tx_start)
          begin
            tx_oe_n_out <= 1'b0;
            tx_ready_out <= 1'b1;
            tx_phase <= mrs_pkg::PH_USER;
            tx_crc <= mrs_pkg::CRC_INIT;
            tx_state <= TX_FETCH;
          end
        end
        TX_FETCH:
        begin
          if (tx_go)
          begin
            tx_ready_out <= 1'b0;
            tx_cnt <= '0;
            tx_left <= nbits;
            tx_state <= TX_SEND;
            case (tx_phase)
              mrs_pkg::PH_USER:
              begin
                // address, function and data come from the user in order
                tx_sh <= build_char(tx_data_in, cfg_in);
                tx_crc <= mrs_pkg::crc_byte(tx_crc,
                                            tx_data_in);
                if (tx_last_in)
                  tx_phase <= mrs_pkg::PH_CRC_LO;
              end
              mrs_pkg::PH_CRC_LO:
              begin
                tx_sh <= build_char(tx_crc[7:0], cfg_in);
                tx_phase <= mrs_pkg::PH_CRC_HI;
              end
              default:
              begin
                tx_sh <= build_char(tx_crc[15:8], cfg_in);
                tx_phase <= mrs_pkg::PH_DONE;
              end
            endcase
          end
        end
        TX_SEND:
        begin
          // one bit per bit time, start bit first
          if (tx_cnt == '0)
          begin
            tx_out <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[10:1]};
          end
          if (tx_cnt >= div - 1'b1)
          begin
            tx_cnt <= '0;
            tx_left <= tx_left - 1'b1;
            if (tx_left == 4'h1)
            begin
              // next character follows at once, no gap
              if (tx_phase == mrs_pkg::PH_DONE)
              begin
                tx_oe_n_out <= 1'b1;
                tx_state <= TX_IDLE;
              end
              else
              begin
                tx_ready_out <= tx_phase == mrs_pkg::PH_USER;
                tx_state <= TX_FETCH;
              end
            end
          end
          else
            tx_cnt <= tx_cnt + 1'b1;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // receive frame buffer
  mrs_frame_ram #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_ram (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .wr_en_in(wr_en),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_data),
    .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out)
  );

endmodule

// >>> tb/mrs_framer_asserts.sv
// port assertions of the rtu slave framer
module mrs_framer_asserts (
  input wire logic clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic ce_in, // enable
  input wire logic rx_in, // line in
  input wire logic tx_out, // line out
  input wire logic tx_oe_n_out, // drive when low
  input wire mrs_pkg::mrs_cfg_s cfg_in, // settings
  input wire logic frame_ok_out, // frame pulse
  input wire mrs_pkg::mrs_frame_s frame_out, // frame info
  input wire logic [7:0] rd_addr_in, // read address
  input wire logic [7:0] rd_data_out, // read data
  input wire logic err_flag_out, // error flag
  input wire logic err_clr_in, // error clear
  input wire logic resp_pend_out, // answer owed
  input wire logic tx_valid_in, // byte valid
  input wire logic [7:0] tx_data_in, // byte
  input wire logic tx_last_in, // last byte
  input wire logic tx_ready_out // byte taken
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // line high one cycle back and eight cycles back
  sequence s_quiet;
    $past(rx_in) && $past(rx_in, 8);
  endsequence
  // driver just switched on
  sequence s_take;
    $fell(tx_oe_n_out);
  endsequence
  a_ok_pulse: assert property (frame_ok_out |=> !frame_ok_out)
    else $error("frame pulse too long");
  a_ok_idle: assert property (frame_ok_out |-> s_quiet)
    else $error("frame judged on busy line");
  a_len_even: assert property (frame_ok_out |-> !frame_out.len[0])
    else $error("odd frame length accepted");
  a_bcast_quiet: assert property (frame_ok_out && frame_out.bcast |=>
    !resp_pend_out) else $error("broadcast owes answer");
  a_answer_owed: assert property (frame_ok_out && !frame_out.bcast |->
    ##[0:1] resp_pend_out) else $error("no answer owed");
  a_take_owed: assert property (s_take |-> $past(resp_pend_out) ##0 s_quiet)
    else $error("driver on without cause");
  a_drive_gated: assert property (!tx_out |-> !tx_oe_n_out)
    else $error("line low while released");
  a_ready_gated: assert property (tx_ready_out |-> !tx_oe_n_out)
    else $error("ready while released");
  a_start_len: assert property ($fell(tx_out) |-> !tx_out [*8])
    else $error("start bit too short");
  a_release_high: assert property ($rose(tx_oe_n_out) |->
    $past(tx_out) && $past(tx_out, 8)) else $error("stop cut");
endmodule
bind mrs_framer mrs_framer_asserts mrs_framer_asserts_inst (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .rx_in(rx_in),
  .tx_out(tx_out), .tx_oe_n_out(tx_oe_n_out), .cfg_in(cfg_in),
  .frame_ok_out(frame_ok_out), .frame_out(frame_out),
  .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
  .err_flag_out(err_flag_out), .err_clr_in(err_clr_in),
  .resp_pend_out(resp_pend_out), .tx_valid_in(tx_valid_in),
  .tx_data_in(tx_data_in), .tx_last_in(tx_last_in),
  .tx_ready_out(tx_ready_out));

// >>> tb/mrs_master_model.sv
// far-side bus master model: sends and collects characters
module mrs_master_model #(
  parameter int DIV = 10 // clocks per bit
) (
  input wire logic clk_in, // clock
  input wire logic tx_in, // slave line out
  input wire logic tx_oe_n_in, // slave driver enable
  output logic rx_out // line toward slave
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [$]; // collected answer bytes
  logic [7:0] rb; // byte being collected
  initial rx_out = 1'b1; // biased line idles high
  // start, eight data lsb first, even parity, one stop
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] c;
    c = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_out <= c[i];
      repeat (DIV) @(posedge clk_in);
    end
  endtask
  // collect slave characters sampled mid-bit
  initial forever
  begin
    @(posedge clk_in);
    if (!tx_oe_n_in && !tx_in)
    begin
      repeat (DIV / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
        repeat (DIV) @(posedge clk_in);
        rb[i] = tx_in;
      end
      repeat (2 * DIV) @(posedge clk_in);
      got.push_back(rb);
    end
  end
endmodule

// >>> tb/modbus_rtu_slave_framer_bench.sv
// self-checking bench of the rtu slave framer
module modbus_rtu_slave_framer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rst_in = 1'b1, rx_in, tx_out, tx_oe_n_out;
  logic frame_ok_out, err_flag_out, resp_pend_out, tx_ready_out;
  logic err_clr_in = 1'b0, tx_valid_in = 1'b0, tx_last_in = 1'b0;
  logic [7:0] rd_addr_in = 8'h00, tx_data_in = 8'h00, rd_data_out;
  mrs_pkg::mrs_cfg_s cfg_in = '{2'h3, 1'b1, 1'b1, 1'b0, 8'h01};
  mrs_pkg::mrs_frame_s frame_out;
  int failures = 0, check_count = 0;
  always #25 clk_in = ~clk_in;
  mrs_framer #(.CLK_HZ(192000)) mrs_framer_inst (.clk_in(clk_in),
    .rst_in(rst_in), .ce_in(1'b1), .rx_in(rx_in), .tx_out(tx_out),
    .tx_oe_n_out(tx_oe_n_out), .cfg_in(cfg_in), .frame_ok_out(frame_ok_out),
    .frame_out(frame_out), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
    .err_flag_out(err_flag_out), .err_clr_in(err_clr_in),
    .resp_pend_out(resp_pend_out), .tx_valid_in(tx_valid_in),
    .tx_data_in(tx_data_in), .tx_last_in(tx_last_in),
    .tx_ready_out(tx_ready_out));
  mrs_master_model #(.DIV(10)) mrs_master_model_inst (.clk_in(clk_in),
    .tx_in(tx_out), .tx_oe_n_in(tx_oe_n_out), .rx_out(rx_in));
  task automatic give_verdict;
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [15:0] crc(input logic [7:0] d [$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (d[i])
    begin
      c ^= {8'h00, d[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic wait_sig(ref logic s, input logic lvl);
    int n;
    n = 0;
    while (s !== lvl)
    begin
      @(negedge clk_in);
      n++;
      if (n > 3000)
      begin
        failures++;
        give_verdict();
      end
    end
  endtask
  task automatic burst(input logic [7:0] d [$]);
    foreach (d[i]) mrs_master_model_inst.send_byte(d[i]);
  endtask
  // frame with check low byte first, then watch for acceptance
  task automatic frame(input logic [7:0] d [$], output logic ok);
    logic [15:0] c;
    c = crc(d);
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
    burst(d);
    ok = 1'b0;
    repeat (600)
    begin
      @(negedge clk_in);
      ok |= frame_ok_out;
    end
  endtask
  task automatic clr;
    @(posedge clk_in);
    err_clr_in <= 1'b1;
    @(posedge clk_in);
    err_clr_in <= 1'b0;
    @(negedge clk_in);
    check("err clear", 0, err_flag_out);
  endtask
  task automatic sc_read;
    logic ok;
    frame('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02}, ok);
    check("read ok", 1, ok);
    check("read len", 8, frame_out.len);
    check("func", 3, frame_out.func);
    check("read owed", 1, resp_pend_out);
    @(posedge clk_in);
    rd_addr_in <= 8'h01;
    @(posedge clk_in);
    @(negedge clk_in);
    check("stored func", 8'h03, rd_data_out);
    mrs_master_model_inst.got.delete();
    @(posedge clk_in);
    tx_valid_in <= 1'b1;
    tx_data_in <= 8'h01;
    wait_sig(tx_ready_out, 1'b1);
    @(posedge clk_in);
    tx_data_in <= 8'h03;
    tx_last_in <= 1'b1;
    @(negedge clk_in);
    wait_sig(tx_ready_out, 1'b1);
    @(posedge clk_in);
    tx_valid_in <= 1'b0;
    wait_sig(tx_oe_n_out, 1'b1);
    check("ans count", 4, mrs_master_model_inst.got.size());
    check("ans crc", 0, crc(mrs_master_model_inst.got));
  endtask
  task automatic sc_bcast;
    logic ok;
    frame('{8'h00, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34}, ok);
    check("bc ok", 1, ok);
    check("bc flag", 1, frame_out.bcast);
    check("bc owed", 0, resp_pend_out);
    frame('{8'h05, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02}, ok);
    check("foreign ok", 0, ok);
    check("foreign err", 0, err_flag_out);
  endtask
  task automatic sc_gaps;
    logic ok;
    burst('{8'h01, 8'h06});
    repeat (250) @(posedge clk_in);
    frame('{8'h01, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34}, ok);
    check("gap ok", 1, ok);
    check("gap len", 8, frame_out.len);
    check("gap err", 1, err_flag_out);
    clr();
    burst('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02, 8'h85, 8'hCA});
    frame('{8'h01, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02}, ok);
    check("join ok", 0, ok);
    check("join err", 1, err_flag_out);
    clr();
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    sc_read();
    sc_bcast();
    sc_gaps();
    give_verdict();
  end
endmodule
